// file: logic/ivh_handler.sv
// Two-level vectored interrupt handler: pending flags, masking, priority, pins
// Notes on behaviour
// - Thirteen sources, each high or low priority
// - Pending flag sets regardless of any enable
// - Enabled pending source makes core long-call vector
// - Routines end with return; core resumes program
// - Disabled source's flag produces no request
// - Global enable zero masks every source
// - Request during enable clear: single-cycle next
// - Software follows enable clear with two-byte opcode
// - Few flags clear on vectoring; software clears rest
// - Flag still set after return re-requests
// - Software writing one acts like real event, except level-mode external flags, which follow the pin
// - Trigger one edge; polarity one active high
// - External inputs watch pins, routing untouched
// - External pending flags in timer control bits
// - Edge-mode external flag clears on vectoring
// - Level-mode external flag follows active input
// - Level source holds input until recognized
// - High preempts low; high never preempted
// - Higher level first, fixed order breaks ties
// - Sample each cycle; call takes four more
// - Vectors from 0x0003, step eight per slot
// - Equal level waits for return plus one
`timescale 1ns/1ps
`default_nettype none
module ivh_handler (
  // Clock and reset
  input  wire logic                           core_clk,
  input  wire logic                           rst,
  // Core side
  ivh_if.handler                              core,
  // Peripheral events and software flag writes, one bit per slot
  input  wire logic [ivh_pkg::NUM_SLOT-1:0]   src_event,
  input  wire logic [ivh_pkg::NUM_SLOT-1:0]   sw_set,
  input  wire logic [ivh_pkg::NUM_SLOT-1:0]   sw_clr,
  // Enable and priority registers
  input  wire logic [7:0]                     irq_enable_reg,
  input  wire logic [7:0]                     extended_irq_enable_reg,
  input  wire logic [7:0]                     irq_priority_reg,
  input  wire logic [7:0]                     extended_irq_priority_reg,
  // External interrupt configuration and pins
  input  wire logic                           ext0_trigger_type,
  input  wire logic                           ext1_trigger_type,
  input  wire logic                           ext0_polarity,
  input  wire logic                           ext1_polarity,
  input  wire logic                           ext_irq0_input,
  input  wire logic                           ext1_irq_input,
  // Status
  output logic      [ivh_pkg::NUM_SLOT-1:0]   pending,
  output logic      [ivh_pkg::TMR_CTL_W-1:0]  timer_control_reg,
  output logic                                ext0_pending,
  output logic                                ext1_pending,
  output logic                                high_in_service,
  output logic                                low_in_service
);
  import ivh_pkg::*;

  // ==========================================================================
  // Lowest set index wins, which gives the fixed order within a level
  function automatic logic [SLOT_W-1:0] first_set(input logic [NUM_SLOT-1:0] v);
    logic [SLOT_W-1:0] r;
    r = '0;
    for (int i = NUM_SLOT - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = SLOT_W'(i);
      end
    end
    return r;
  endfunction

  // ==========================================================================
  // External pin conditioning
  wire logic [NUM_EXT-1:0] ext_pin  = {ext1_irq_input, ext_irq0_input};
  wire logic [NUM_EXT-1:0] ext_pol  = {ext1_polarity, ext0_polarity};
  wire logic [NUM_EXT-1:0] ext_trig = {ext1_trigger_type, ext0_trigger_type};
  logic      [NUM_EXT-1:0] ext_active;
  logic      [NUM_EXT-1:0] ext_edge;

  generate
    for (genvar c = 0; c < NUM_EXT; c++) begin : g_ext
      logic [SYNC_STAGES-1:0] sync_q;
      logic                   filt_q;
      logic                   act_prev_q;
      wire logic              agree = (sync_q[1] == sync_q[2]);
      wire logic              act   = ext_pol[c] ? filt_q : ~filt_q;

      // Pin only observed, never driven, so routed peripherals are unaffected
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          sync_q     <= {SYNC_STAGES{EXT_IDLE_LEVEL}};
          filt_q     <= EXT_IDLE_LEVEL;
          // Starts as active so that neither polarity sees a false edge after reset
          act_prev_q <= 1'b1;
        end else begin
          sync_q     <= {sync_q[SYNC_STAGES-2:0], ext_pin[c]};
          filt_q     <= agree ? sync_q[2] : filt_q;
          act_prev_q <= act;
        end
      end

      assign ext_active[c] = act;
      assign ext_edge[c]   = act & ~act_prev_q;
    end
  endgenerate

  // ==========================================================================
  // Pending flags
  logic [NUM_SLOT-1:0] pend_q;
  logic [NUM_SLOT-1:0] pend_d;
  logic [NUM_SLOT-1:0] hw_clr;

  generate
    for (genvar i = 0; i < NUM_SLOT; i++) begin : g_slot
      localparam bit IS_EXT = (i == SLOT_EXT0) || (i == SLOT_EXT1);
      localparam int CH     = (i == SLOT_EXT0) ? 0 : 1;
      wire logic hit = core.irq_ack && (core.ack_slot == SLOT_W'(i));

      if (RESERVED_MASK[i]) begin : g_rsv
        assign hw_clr[i] = 1'b0;
        assign pend_d[i] = 1'b0;
      end else if (IS_EXT) begin : g_x
        assign hw_clr[i] = hit & ext_trig[CH];
        // Level mode mirrors the input; edge mode is sticky, set beats clear
        assign pend_d[i] = ext_trig[CH]
                         ? (ext_edge[CH] | sw_set[i] | (pend_q[i] & ~(sw_clr[i] | hw_clr[i])))
                         : ext_active[CH];
      end else begin : g_p
        assign hw_clr[i] = hit & HWCLR_MASK[i];
        assign pend_d[i] = src_event[i] | sw_set[i]
                         | (pend_q[i] & ~(sw_clr[i] | hw_clr[i]));
      end
    end
  endgenerate

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pend_q <= '0;
    end else begin
      pend_q <= pend_d;
    end
  end

  // ==========================================================================
  // Masking and priority decode, once per clock
  wire logic                glb_en  = irq_enable_reg[GLB_EN_BIT];
  wire logic [NUM_SLOT-1:0] src_en  = {extended_irq_enable_reg,
                                       irq_enable_reg[SRC_EN_BITS-1:0]};
  wire logic [NUM_SLOT-1:0] src_pri = {extended_irq_priority_reg,
                                       irq_priority_reg[SRC_EN_BITS-1:0]};
  wire logic [NUM_SLOT-1:0] eligible = pend_q & src_en & {NUM_SLOT{glb_en}}
                                     & ~RESERVED_MASK;
  wire logic [NUM_SLOT-1:0] hi_req = eligible & src_pri;
  wire logic [NUM_SLOT-1:0] lo_req = eligible & ~src_pri;

  logic hi_act_q;
  logic lo_act_q;

  // A running high routine blocks everything; a low one blocks only low
  wire logic take_hi  = (|hi_req) & ~hi_act_q;
  wire logic take_lo  = ~(|hi_req) & (|lo_req) & ~hi_act_q & ~lo_act_q;
  wire logic take     = take_hi | take_lo;
  wire logic [SLOT_W-1:0] win_slot = take_hi ? first_set(hi_req) : first_set(lo_req);
  wire logic [VEC_W-1:0]  win_vec  = VEC_BASE + (VEC_W'(win_slot) << VEC_SHIFT);

  logic                req_q;
  logic [VEC_W-1:0]    vec_q;
  logic [SLOT_W-1:0]   slot_q;
  logic                high_q;

  // Registered request is the one detection cycle ahead of the call
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      req_q  <= 1'b0;
      vec_q  <= RESET_VECTOR;
      slot_q <= '0;
      high_q <= 1'b0;
    end else begin
      req_q  <= take & ~core.irq_ack;
      vec_q  <= win_vec;
      slot_q <= win_slot;
      high_q <= take_hi;
    end
  end

  // ==========================================================================
  // In-service levels: set on vectoring, innermost level released on return
  wire logic ret_hi = core.ret_done & hi_act_q;
  wire logic ret_lo = core.ret_done & ~hi_act_q;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      hi_act_q <= 1'b0;
      lo_act_q <= 1'b0;
    end else begin
      hi_act_q <= (core.irq_ack & core.ack_high) | (hi_act_q & ~ret_hi);
      lo_act_q <= (core.irq_ack & ~core.ack_high) | (lo_act_q & ~ret_lo);
    end
  end

  // ==========================================================================
  // Outputs
  assign core.irq_req    = req_q;
  assign core.irq_vector = vec_q;
  assign core.irq_slot   = slot_q;
  assign core.irq_high   = high_q;

  assign pending         = pend_q;
  assign ext0_pending    = pend_q[SLOT_EXT0];
  assign ext1_pending    = pend_q[SLOT_EXT1];
  assign high_in_service = hi_act_q;
  assign low_in_service  = lo_act_q;

  always_comb begin
    timer_control_reg               = '0;
    timer_control_reg[TMR_CTL_TRIG0_BIT] = ext0_trigger_type;
    timer_control_reg[TMR_CTL_PEND0_BIT] = pend_q[SLOT_EXT0];
    timer_control_reg[TMR_CTL_TRIG1_BIT] = ext1_trigger_type;
    timer_control_reg[TMR_CTL_PEND1_BIT] = pend_q[SLOT_EXT1];
  end

endmodule // ivh_handler
`default_nettype wire

// file: logic/ivh_pkg.sv
// Shared constants and types for the vectored interrupt handler and its core end
package ivh_pkg;

  // ==========================================================================
  // Source slots
  localparam int NUM_SLOT  = 15;
  localparam int SLOT_W    = 4;
  localparam int NUM_EXT   = 2;
  localparam int SLOT_EXT0 = 0;
  localparam int SLOT_EXT1 = 2;
  localparam int SRC_EN_BITS = 7;
  localparam int GLB_EN_BIT  = 7;

  // Slots 8 and 13 hold no source; slots 1 and 3 clear on vectoring
  localparam logic [NUM_SLOT-1:0] RESERVED_MASK = 15'h2100;
  localparam logic [NUM_SLOT-1:0] HWCLR_MASK    = 15'h000A;

  // ==========================================================================
  // Vectors
  localparam int                VEC_W        = 16;
  localparam int                VEC_SHIFT    = 3;
  localparam logic [VEC_W-1:0]  VEC_BASE     = 16'h0003;
  localparam logic [VEC_W-1:0]  RESET_VECTOR = 16'h0000;

  // ==========================================================================
  // Timer control flag positions
  localparam int TMR_CTL_W          = 8;
  localparam int TMR_CTL_TRIG0_BIT  = 0;
  localparam int TMR_CTL_PEND0_BIT  = 1;
  localparam int TMR_CTL_TRIG1_BIT  = 2;
  localparam int TMR_CTL_PEND1_BIT  = 3;

  // ==========================================================================
  // Timing and pin conditioning
  localparam int   DETECT_CYC     = 1;
  localparam int   CALL_CYC       = 4;
  localparam int   CNT_W          = 3;
  localparam int   SYNC_STAGES    = 3;
  localparam logic EXT_IDLE_LEVEL = 1'b1;

  typedef enum logic [0:0] {
    IVH_ST_IDLE = 1'b0,
    IVH_ST_CALL = 1'b1
  } ivh_call_state_t;

endpackage

// file: logic/ivh_if.sv
// Link between the interrupt handler and the core end
`timescale 1ns/1ps
`default_nettype none
interface ivh_if;
  import ivh_pkg::*;

  logic                irq_req;
  logic [VEC_W-1:0]    irq_vector;
  logic [SLOT_W-1:0]   irq_slot;
  logic                irq_high;
  logic                irq_ack;
  logic [SLOT_W-1:0]   ack_slot;
  logic                ack_high;
  logic                ret_done;

  modport handler (
    output irq_req,
    output irq_vector,
    output irq_slot,
    output irq_high,
    input  irq_ack,
    input  ack_slot,
    input  ack_high,
    input  ret_done
  );

  modport core (
    input  irq_req,
    input  irq_vector,
    input  irq_slot,
    input  irq_high,
    output irq_ack,
    output ack_slot,
    output ack_high,
    output ret_done
  );
endinterface
`default_nettype wire

// file: logic/ivh_core_end.sv
// Core end: takes requests at instruction boundaries and runs the long call
`timescale 1ns/1ps
`default_nettype none
module ivh_core_end (
  // Clock and reset
  input  wire logic                        core_clk,
  input  wire logic                        rst,
  // Handler side
  ivh_if.core                              hnd,
  // Instruction stream from the core
  input  wire logic                        instr_done,
  input  wire logic                        instr_is_ret,
  input  wire logic                        instr_clears_glb_en,
  input  wire logic                        next_multi_cycle,
  // Long call to the core
  output logic                             call_start,
  output logic                             call_done,
  output logic                             call_active,
  output logic      [ivh_pkg::VEC_W-1:0]   call_vector
);
  import ivh_pkg::*;

  ivh_call_state_t      state_q;
  logic [CNT_W-1:0]     cnt_q;
  logic                 grace_q;
  logic [VEC_W-1:0]     g_vec_q;
  logic [SLOT_W-1:0]    g_slot_q;
  logic                 g_high_q;
  logic [VEC_W-1:0]     vec_q;

  // ==========================================================================
  // Boundary decisions
  wire logic idle     = (state_q == IVH_ST_IDLE);
  wire logic boundary = instr_done & idle;
  // Request seen while the enable is being cleared survives one short opcode
  wire logic arm      = boundary & instr_clears_glb_en & ~next_multi_cycle
                      & hnd.irq_req;
  // The registered request cannot rise before the boundary after a return,
  // so exactly one further instruction runs before re-entry
  wire logic take     = boundary & ~instr_clears_glb_en & ~instr_is_ret
                      & (hnd.irq_req | grace_q);
  wire logic last     = (state_q == IVH_ST_CALL) && (cnt_q == '0);

  assign hnd.irq_ack   = take;
  assign hnd.ack_slot  = grace_q ? g_slot_q : hnd.irq_slot;
  assign hnd.ack_high  = grace_q ? g_high_q : hnd.irq_high;
  assign hnd.ret_done  = boundary & instr_is_ret;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      grace_q  <= 1'b0;
      g_vec_q  <= RESET_VECTOR;
      g_slot_q <= '0;
      g_high_q <= 1'b0;
    end else begin
      grace_q  <= boundary ? arm : grace_q;
      g_vec_q  <= arm ? hnd.irq_vector : g_vec_q;
      g_slot_q <= arm ? hnd.irq_slot : g_slot_q;
      g_high_q <= arm ? hnd.irq_high : g_high_q;
    end
  end

  // ==========================================================================
  // Long call sequencer
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q <= IVH_ST_IDLE;
      cnt_q   <= '0;
      vec_q   <= RESET_VECTOR;
    end else begin
      case (state_q)
        IVH_ST_IDLE: begin
          if (take) begin
            state_q <= IVH_ST_CALL;
            cnt_q   <= CNT_W'(CALL_CYC - 1);
            vec_q   <= grace_q ? g_vec_q : hnd.irq_vector;
          end
        end
        IVH_ST_CALL: begin
          if (last) begin
            state_q <= IVH_ST_IDLE;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        default: begin
          state_q <= IVH_ST_IDLE;
        end
      endcase
    end
  end

  assign call_start  = take;
  assign call_done   = last;
  assign call_active = ~idle;
  assign call_vector = vec_q;

endmodule // ivh_core_end
`default_nettype wire

// file: verif/ivh_link_properties.sv
// Protocol checks on the link between the interrupt handler and the core end
`timescale 1ns/1ps
`default_nettype none
module ivh_link_properties (
  // Clock and reset
  input wire logic                         core_clk,
  input wire logic                         rst,
  // Handler to core
  input wire logic                         irq_req,
  input wire logic [ivh_pkg::VEC_W-1:0]    irq_vector,
  input wire logic [ivh_pkg::SLOT_W-1:0]   irq_slot,
  input wire logic                         irq_high,
  // Core to handler
  input wire logic                         irq_ack,
  input wire logic [ivh_pkg::SLOT_W-1:0]   ack_slot,
  input wire logic                         ack_high,
  input wire logic                         ret_done
);
  import ivh_pkg::*;
  logic hi_q;
  logic lo_q;
  // ==========================================================================
  // In-service levels rebuilt from the link alone, so no design internals are needed
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      hi_q <= 1'h0;
    end else if (irq_ack && ack_high) begin
      hi_q <= 1'h1;
    end else if (ret_done) begin
      hi_q <= 1'h0;
    end
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      lo_q <= 1'h0;
    end else if (irq_ack && !ack_high) begin
      lo_q <= 1'h1;
    end else if (ret_done && !hi_q) begin
      lo_q <= 1'h0;
    end
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  // ==========================================================================
  // Assertions
  a_vector_from_slot: assert property (irq_req |-> irq_vector == VEC_BASE + {irq_slot, 3'h0})
    else $error("request vector does not match its slot");
  a_no_reserved_slot: assert property (irq_req |-> !RESERVED_MASK[irq_slot])
    else $error("request raised for a reserved slot");
  a_ack_drops_req: assert property (irq_ack |=> !irq_req)
    else $error("request still up after acknowledge");
  a_ack_takes_winner: assert property (irq_ack && irq_req |-> ack_slot == irq_slot && ack_high == irq_high)
    else $error("acknowledged slot differs from offered winner");
  a_call_spacing: assert property (irq_ack |=> !irq_ack [*4])
    else $error("second acknowledge inside a long call");
  a_ret_one_instr: assert property (ret_done |-> !irq_ack ##1 !irq_ack)
    else $error("vectored without one instruction after return");
  a_high_not_preempted: assert property (hi_q |-> !irq_req)
    else $error("request offered while high level in service");
  a_low_only_high: assert property (lo_q && !hi_q |-> !irq_req || irq_high)
    else $error("low request offered while low level in service");
  // Main scenarios
  c_preempt: cover property (irq_ack && ack_high && lo_q);
  c_reentry: cover property (ret_done ##2 irq_req);
  c_low_take: cover property (irq_ack && !ack_high);
endmodule // ivh_link_properties
`default_nettype wire

// file: verif/two_level_vectored_interrupt_handler_test.sv
// Self-checking bench: handler and core end joined over the link
`timescale 1ns/1ps
`default_nettype none
module two_level_vectored_interrupt_handler_test;
  import ivh_pkg::*;
  logic                core_clk, rst, glb_en, instr_done, instr_is_ret;
  logic                instr_clears_glb_en, next_multi_cycle;
  logic                ext0_trigger_type, ext1_trigger_type, ext0_polarity, ext1_polarity;
  logic                ext_irq0_input, ext1_irq_input, ext0_pending, ext1_pending;
  logic                high_in_service, low_in_service, call_start, call_done, call_active;
  logic [NUM_SLOT-1:0] src_event, sw_set, sw_clr, en, pr, pending;
  logic [7:0]          irq_enable_reg, extended_irq_enable_reg;
  logic [7:0]          irq_priority_reg, extended_irq_priority_reg;
  logic [TMR_CTL_W-1:0] timer_control_reg;
  logic [VEC_W-1:0]    call_vector;
  logic [VEC_W-1:0]    exp_q[$];
  int                  fail_count, n_tests;
  assign irq_enable_reg            = {glb_en, en[6:0]};
  assign extended_irq_enable_reg   = en[14:7];
  assign irq_priority_reg          = {1'h0, pr[6:0]};
  assign extended_irq_priority_reg = pr[14:7];
  ivh_if link ();
  ivh_handler ivh_handler_inst (.core_clk, .rst, .core(link), .src_event, .sw_set, .sw_clr,
    .irq_enable_reg, .extended_irq_enable_reg, .irq_priority_reg, .extended_irq_priority_reg,
    .ext0_trigger_type, .ext1_trigger_type, .ext0_polarity, .ext1_polarity, .ext_irq0_input,
    .ext1_irq_input, .pending, .timer_control_reg, .ext0_pending, .ext1_pending,
    .high_in_service, .low_in_service);
  ivh_core_end ivh_core_end_inst (.core_clk, .rst, .hnd(link), .instr_done, .instr_is_ret,
    .instr_clears_glb_en, .next_multi_cycle, .call_start, .call_done, .call_active,
    .call_vector);
  ivh_link_properties ivh_link_properties_inst (.core_clk, .rst, .irq_req(link.irq_req),
    .irq_vector(link.irq_vector), .irq_slot(link.irq_slot), .irq_high(link.irq_high),
    .irq_ack(link.irq_ack), .ack_slot(link.ack_slot), .ack_high(link.ack_high),
    .ret_done(link.ret_done));
  // ==========================================================================
  // Clock, watchdog and reporting
  initial begin
    core_clk = 1'h0;
    forever #50 core_clk = ~core_clk;
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    $display("[ERR] %0t run did not finish", $time);
    results();
  end
  task automatic results();
    $display("comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk_vec(input logic [VEC_W-1:0] got, input logic [VEC_W-1:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t call vector %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t flag %b, expected %b", $time, got, exp);
    end
  endtask
  // Every finished long call must match the oldest expected vector; an empty queue means a stray call
  always @(negedge core_clk) begin
    if (call_done === 1'h1) begin
      if (exp_q.size() == 0) begin
        fail_count++;
        $display("[ERR] %0t call that nobody asked for", $time);
      end else begin
        chk_vec(call_vector, exp_q.pop_front());
      end
    end
  end
  // ==========================================================================
  // Drivers
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic setf(input logic [NUM_SLOT-1:0] m, input bit ev);
    @(posedge core_clk);
    if (ev) src_event <= m;
    else sw_set <= m;
    @(posedge core_clk);
    src_event <= '0;
    sw_set <= '0;
  endtask
  task automatic take(input int s);
    int i;
    exp_q.push_back(VEC_BASE + 16'(8 * s));
    for (i = 0; i < 60; i++) begin
      @(posedge core_clk);
      #1;
      if (call_done === 1'h1) break;
    end
    if (call_done !== 1'h1) begin
      fail_count++;
      $display("[ERR] %0t expected call never came", $time);
      results();
    end
  endtask
  // Routine epilogue: optional software clear, then the return
  task automatic ret(input int c);
    @(posedge core_clk);
    if (c >= 0) sw_clr[c] <= 1'h1;
    @(posedge core_clk);
    sw_clr <= '0;
    instr_is_ret <= 1'h1;
    @(posedge core_clk);
    instr_is_ret <= 1'h0;
  endtask
  // ==========================================================================
  // Scenarios
  initial begin
    int s;
    int k;
    void'($urandom(32'h9c19));
    {rst, instr_done, glb_en, instr_is_ret, ext_irq0_input, ext0_trigger_type} = 6'h33;
    {instr_clears_glb_en, next_multi_cycle} = 2'h0;
    {ext0_polarity, ext1_trigger_type, ext1_polarity, ext1_irq_input} = 4'h2;
    {src_event, sw_set, sw_clr, en, pr} = '0;
    {fail_count, n_tests} = '0;
    tick(2);
    rst <= 1'h0;
    s = 3 + int'($urandom % 5);
    en <= 15'h7FFB;
    setf(15'h0001 << s, 1'b1);
    tick(10);
    @(negedge core_clk);
    chk_bit(pending[s], 1'h1);
    chk_bit(call_active, 1'h0);
    tick(1);
    glb_en <= 1'h1;
    en <= '0;
    tick(10);
    @(negedge core_clk);
    chk_bit(call_active, 1'h0);
    tick(1);
    en <= 15'h7FFB;
    take(s);
    ret(s);
    $display("masking test done");
    for (k = 0; k < 2; k++) begin
      pr <= (k == 1) ? 15'h0200 : 15'h0000;
      setf(15'h0220, 1'b0);
      take(k == 1 ? 9 : 5);
      ret(k == 1 ? 9 : 5);
      take(k == 1 ? 5 : 9);
      ret(k == 1 ? 5 : 9);
    end
    $display("priority order test done");
    pr <= 15'h0002;
    setf(15'h0040, 1'b0);
    take(6);
    setf(15'h0002, 1'b0);
    take(1);
    chk_bit(pending[1], 1'h0);
    chk_bit(high_in_service, 1'h1);
    chk_bit(low_in_service, 1'h1);
    setf(15'h0010, 1'b0);
    tick(10);
    ret(-1);
    tick(10);
    ret(6);
    take(4);
    ret(4);
    $display("preemption test done");
    setf(15'h0080, 1'b0);
    take(7);
    ret(-1);
    take(7);
    ret(7);
    $display("re-entry test done");
    tick(1);
    ext_irq0_input <= 1'h0;
    take(0);
    chk_bit(pending[0], 1'h0);
    chk_bit(ext0_pending, 1'h0);
    chk_bit(timer_control_reg[TMR_CTL_TRIG0_BIT], 1'h1);
    tick(1);
    ext_irq0_input <= 1'h1;
    ret(-1);
    for (k = 0; k < 2; k++) begin
      ext1_polarity <= k[0];
      ext1_irq_input <= k[0];
      tick(8);
      @(negedge core_clk);
      chk_bit(ext1_pending, 1'h1);
      chk_bit(timer_control_reg[3], 1'h1);
      tick(1);
      ext1_irq_input <= !k[0];
      tick(8);
      @(negedge core_clk);
      chk_bit(timer_control_reg[3], 1'h0);
    end
    // Level source held active until taken, released before the return
    en <= 15'h7FFF;
    ext1_irq_input <= 1'h1;
    take(2);
    tick(1);
    ext1_irq_input <= 1'h0;
    tick(8);
    ret(-1);
    $display("external pin test done");
    // Request meets an enable clear: kept only before a short opcode
    for (k = 0; k < 2; k++) begin
      setf(15'h0080, 1'b0);
      tick(1);
      instr_clears_glb_en <= 1'h1;
      next_multi_cycle <= (k == 0);
      glb_en <= 1'h0;
      tick(1);
      instr_clears_glb_en <= 1'h0;
      next_multi_cycle <= 1'h0;
      if (k == 0) begin
        tick(10);
        @(negedge core_clk);
        chk_bit(call_active, 1'h0);
        tick(1);
        glb_en <= 1'h1;
      end
      take(7);
      ret(7);
      glb_en <= 1'h1;
    end
    $display("enable clear test done");
    tick(20);
    chk_bit(exp_q.size() == 0, 1'h1);
    results();
  end
endmodule // two_level_vectored_interrupt_handler_test
`default_nettype wire
